// ---- rcm_defines.svh ----
// register offsets, field positions, reset values and timing constants
// included by the monitor top; holds definitions only
`ifndef RCM_DEFINES_SVH
`define RCM_DEFINES_SVH

`define RCM_OFS_CFG 12'h000
`define RCM_OFS_SEL 12'h004
`define RCM_OFS_SYSPER 12'h008
`define RCM_OFS_STAB 12'h00C
`define RCM_OFS_OVR 12'h010
`define RCM_OFS_STATUS 12'h014
`define RCM_OFS_ASSIGN 12'h018
`define RCM_PROF_PAGE 4'h1

`define RCM_PF_PER_LO 3'h0
`define RCM_PF_PER_HI 3'h1
`define RCM_PF_INNER 3'h2
`define RCM_PF_OUTER 3'h3
`define RCM_PF_TIMERS 3'h4

`define RCM_OVR_FORCE_LSB 0
`define RCM_OVR_OVR_LSB 8
`define RCM_OVR_BYP_LSB 16
`define RCM_TMR_REDET_LSB 16

`define RCM_CLK_PERIOD_NS 32'h19
`define RCM_FS_PER_NS 32'h3E8
`define RCM_FS_PER_MS 41'hE8D4A51000
`define RCM_SYSPER_RST (`RCM_CLK_PERIOD_NS * `RCM_FS_PER_NS * `RCM_FS_PER_NS)
`define RCM_STAB_MS_RST 16'h0000

`endif

// ---- rcm_period_meter.sv ----
// period meter for one reference: counts system clocks between rising edges
// assumes i_level is already synchronised to i_clk
`timescale 1ns/100ps
module rcm_period_meter import rcm_pkg::*; #(
    parameter int CNT_W = 17
) (
    // clock and control
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // reference and scale
    input wire logic i_level,
    input wire logic [31:0] i_sysper,
    // measurement
    output logic [39:0] o_meas,
    output logic o_meas_valid
);
    typedef struct packed {
        logic prev;
        logic primed;
        logic [CNT_W-1:0] cnt;
        logic [39:0] meas;
        logic mv;
    } rcm_meter_t;

    rcm_meter_t q;
    rcm_meter_t d;
    logic [CNT_W+31:0] prod;

    // cycles times system clock period gives femtoseconds
    assign prod = ({32'h0, q.cnt} + (CNT_W+32)'(1)) * {{CNT_W{1'b0}}, i_sysper};

    always_comb begin
        d = q;
        d.mv = 1'b0;
        d.prev = i_level;
        if (i_level && !q.prev) begin
            // the first edge only opens a window
            if (q.primed) begin
                d.meas = (|prod[CNT_W+31:40]) ? 40'hFFFFFFFFFF : prod[39:0];
                d.mv = 1'b1;
            end
            d.primed = 1'b1;
            d.cnt = '0;
        end else if (&q.cnt) begin
            // a stopped reference still yields a (failing) measurement
            d.meas = 40'hFFFFFFFFFF;
            d.mv = 1'b1;
            d.primed = 1'b0;
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_meas = q.meas;
    assign o_meas_valid = q.mv;
endmodule : rcm_period_meter

// ---- rcm_pkg.sv ----
// types shared by the reference clock monitor modules
// assumes nothing beyond a SystemVerilog compiler
package rcm_pkg;

    typedef enum logic {RCM_ASG_NULL, RCM_ASG_HELD} rcm_asg_t;

    typedef struct packed {
        logic [39:0] period;
        logic [19:0] inner;
        logic [19:0] outer;
        logic [15:0] val_ms;
        logic [15:0] redet_ms;
    } rcm_prof_t;

    typedef struct packed {
        logic fprev;
        logic [15:0] vcnt;
        logic [15:0] rcnt;
        logic valid;
        logic redet;
    } rcm_val_t;

    typedef struct packed {
        logic [1:0] s1p;
        logic [1:0] s1n;
        logic [1:0] s2p;
        logic [1:0] s2n;
        logic [1:0] diff;
        logic [15:0] sel;
        logic [31:0] sysper;
        logic [15:0] stab_ms;
        logic [15:0] stab_cnt;
        logic stable;
        logic [40:0] acc;
        logic tick;
        logic [3:0] force_v;
        logic [3:0] ovr;
        logic [3:0] byp;
        logic [3:0] mon_fault;
        rcm_asg_t [3:0] asg;
        logic [3:0][2:0] pidx;
        logic [3:0][2:0] scan;
        rcm_prof_t [7:0] prof;
        logic dp_wr;
        logic [11:0] dp_addr;
        logic [31:0] rdata;
    } rcm_top_t;

endpackage : rcm_pkg

// ---- rcm_ref_src.sv ----
// stand-in for one external reference oscillator feeding a reference pin
// assumes i_clk is the system clock; the level toggles every i_half clocks while running
`timescale 1ns/100ps
module rcm_ref_src (
    // control
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_half,
    // reference level
    output logic o_level
);
    logic [7:0] cnt;

    initial begin
        cnt = 8'h00;
        o_level = 1'b0;
    end

    // a stopped single-ended receiver rests on its pull-down, so the level falls to 0
    always @(posedge i_clk) begin
        if (!i_run) begin
            cnt <= 8'h00;
            o_level <= 1'b0;
        end else if (cnt + 8'h01 >= i_half) begin
            cnt <= 8'h00;
            o_level <= ~o_level;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : rcm_ref_src

// ---- rcm_top.sv ----
// reference clock monitor and validation for four reference inputs
// assumes an AHB-Lite master on i_clk and reference pins asynchronous to it
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "rcm_defines.svh"
module rcm_top import rcm_pkg::*; #(
    parameter int CNT_W = 17
) (
    // clock and control
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [11:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // reference pin pairs
    input wire logic [1:0] i_ref_p,
    input wire logic [1:0] i_ref_n,
    // reference status
    output logic [3:0] o_valid
);
    rcm_top_t q;
    rcm_top_t d;
    logic [3:0] man;
    logic [3:0][2:0] pe;
    logic [3:0] dis;
    logic [3:0] lvl;
    logic [3:0] faulted;
    logic [3:0][39:0] meas;
    logic [3:0] mval;
    logic [3:0] redet;
    logic [15:0] asg_word;
    logic [40:0] acc_sum;
    logic accept;
    logic [31:0] rd_word;
    logic [6:0] rdec;
    logic [6:0] wdec;

    // deviation within tolerance when |meas-nom| * recip <= nom
    // a reciprocal of zero accepts any period, so a blank profile matches every reference
    function automatic logic rcm_within(input logic [39:0] m, input logic [39:0] nom,
                                        input logic [19:0] recip);
        logic [39:0] dev;
        logic [59:0] scaled;
        dev = (m >= nom) ? m - nom : nom - m;
        scaled = {20'h00000, dev} * {40'h0000000000, recip};
        rcm_within = scaled <= {20'h00000, nom};
    endfunction : rcm_within

    // {hit, profile, field} of a profile page address
    function automatic logic [6:0] rcm_prof_dec(input logic [11:0] a);
        rcm_prof_dec = {a[11:8] == `RCM_PROF_PAGE, a[7:5], a[4:2]};
    endfunction : rcm_prof_dec

    for (genvar g = 0; g < 4; g++) begin : g_ref
        assign man[g] = q.sel[4*g+3];
        assign pe[g] = man[g] ? q.sel[4*g+:3] : (q.asg[g] == RCM_ASG_HELD ? q.pidx[g] : q.scan[g]);
        // the second receiver of a pair is unused in differential mode
        if (g % 2 == 1) begin : g_se
            assign dis[g] = q.diff[g/2];
            assign lvl[g] = q.s2n[g/2] & ~q.diff[g/2];
        end else begin : g_dp
            assign dis[g] = 1'b0;
            assign lvl[g] = q.s2p[g/2];
        end
        assign faulted[g] = q.byp[g] ? q.ovr[g] : (q.ovr[g] | q.mon_fault[g] | ~q.stable | dis[g]);
        assign asg_word[4*g+:4] = {q.asg[g] == RCM_ASG_HELD, q.pidx[g]};

        rcm_period_meter #(.CNT_W(CNT_W)) u_meter (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_ce(i_ce),
            .i_level(lvl[g]),
            .i_sysper(q.sysper),
            .o_meas(meas[g]),
            .o_meas_valid(mval[g])
        );

        rcm_validator u_val (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_ce(i_ce),
            .i_faulted(faulted[g]),
            .i_ms_tick(q.tick),
            .i_val_ms(q.prof[pe[g]].val_ms),
            .i_redet_ms(q.prof[pe[g]].redet_ms),
            .i_redet_en(~man[g]),
            .i_force(q.force_v[g]),
            .o_valid(o_valid[g]),
            .o_redetect(redet[g])
        );

        // an automatic reference that times out in fault loses its profile
        sequence s_drop;
            i_ce && redet[g] && !man[g] && q.asg[g] == RCM_ASG_HELD;
        endsequence
        property p_drop;
            @(posedge i_clk) disable iff (i_reset) s_drop |=> q.asg[g] == RCM_ASG_NULL && q.mon_fault[g];
        endproperty
        redet_drop_a: assert property (p_drop)
            else $error("redetect expiry kept the assignment");
    end

    assign acc_sum = q.acc + {9'h000, q.sysper};
    assign accept = i_hsel && i_htrans[1] && i_hready && i_hsize == 3'h2;
    assign rdec = rcm_prof_dec(i_haddr);
    assign wdec = rcm_prof_dec(q.dp_addr);

    always_comb begin
        rd_word = 32'h00000000;
        case (i_haddr)
            `RCM_OFS_CFG: rd_word = {30'h00000000, q.diff};
            `RCM_OFS_SEL: rd_word = {16'h0000, q.sel};
            `RCM_OFS_SYSPER: rd_word = q.sysper;
            `RCM_OFS_STAB: rd_word = {16'h0000, q.stab_ms};
            `RCM_OFS_OVR: rd_word = {12'h000, q.byp, 4'h0, q.ovr, 8'h00};
            `RCM_OFS_STATUS: rd_word = {23'h000000, q.stable, faulted, o_valid};
            `RCM_OFS_ASSIGN: rd_word = {16'h0000, asg_word};
            default: begin
                if (rdec[6]) begin
                    case (rdec[2:0])
                        `RCM_PF_PER_LO: rd_word = q.prof[rdec[5:3]].period[31:0];
                        `RCM_PF_PER_HI: rd_word = {24'h000000, q.prof[rdec[5:3]].period[39:32]};
                        `RCM_PF_INNER: rd_word = {12'h000, q.prof[rdec[5:3]].inner};
                        `RCM_PF_OUTER: rd_word = {12'h000, q.prof[rdec[5:3]].outer};
                        `RCM_PF_TIMERS: rd_word = {q.prof[rdec[5:3]].redet_ms, q.prof[rdec[5:3]].val_ms};
                        default: rd_word = 32'h00000000;
                    endcase
                end
            end
        endcase
    end

    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.force_v = 4'h0;
        d.s1p = i_ref_p;
        d.s1n = i_ref_n;
        d.s2p = q.s1p;
        d.s2n = q.s1n;
        // fractional accumulator keeps the tick exact on average
        if (acc_sum >= `RCM_FS_PER_MS) begin
            d.acc = acc_sum - `RCM_FS_PER_MS;
            d.tick = 1'b1;
        end else begin
            d.acc = acc_sum;
        end
        if (q.tick && !q.stable) begin
            if (q.stab_cnt >= q.stab_ms) begin
                d.stable = 1'b1;
            end else begin
                d.stab_cnt = q.stab_cnt + 16'h0001;
            end
        end
        for (int r = 0; r < 4; r++) begin
            case (q.asg[r])
                RCM_ASG_NULL: begin
                    if (mval[r] && man[r]) begin
                        d.mon_fault[r] = !rcm_within(meas[r], q.prof[pe[r]].period,
                            q.mon_fault[r] ? q.prof[pe[r]].inner : q.prof[pe[r]].outer);
                    end else if (mval[r]) begin
                        // one candidate profile per measurement
                        if (rcm_within(meas[r], q.prof[q.scan[r]].period, q.prof[q.scan[r]].outer)) begin
                            d.asg[r] = RCM_ASG_HELD;
                            d.pidx[r] = q.scan[r];
                        end else begin
                            d.scan[r] = q.scan[r] + 3'h1;
                        end
                    end
                end
                RCM_ASG_HELD: begin
                    if (redet[r] && !man[r]) begin
                        d.asg[r] = RCM_ASG_NULL;
                        d.mon_fault[r] = 1'b1;
                    end else if (mval[r]) begin
                        d.mon_fault[r] = !rcm_within(meas[r], q.prof[pe[r]].period,
                            q.mon_fault[r] ? q.prof[pe[r]].inner : q.prof[pe[r]].outer);
                    end
                end
                default: d.asg[r] = RCM_ASG_NULL;
            endcase
        end
        // bus: one-cycle address phase, zero-wait data phase
        d.dp_wr = accept && i_hwrite;
        d.dp_addr = i_haddr;
        if (accept && !i_hwrite) begin
            d.rdata = rd_word;
        end
        if (q.dp_wr) begin
            case (q.dp_addr)
                `RCM_OFS_CFG: d.diff = i_hwdata[1:0];
                `RCM_OFS_SEL: d.sel = i_hwdata[15:0];
                `RCM_OFS_SYSPER: d.sysper = i_hwdata;
                `RCM_OFS_STAB: begin
                    d.stab_ms = i_hwdata[15:0];
                    d.stab_cnt = 16'h0000;
                    d.stable = 1'b0;
                end
                `RCM_OFS_OVR: begin
                    d.force_v = i_hwdata[`RCM_OVR_FORCE_LSB+:4];
                    d.ovr = i_hwdata[`RCM_OVR_OVR_LSB+:4];
                    d.byp = i_hwdata[`RCM_OVR_BYP_LSB+:4];
                end
                default: begin
                    if (wdec[6]) begin
                        case (wdec[2:0])
                            `RCM_PF_PER_LO: d.prof[wdec[5:3]].period[31:0] = i_hwdata;
                            `RCM_PF_PER_HI: d.prof[wdec[5:3]].period[39:32] = i_hwdata[7:0];
                            `RCM_PF_INNER: d.prof[wdec[5:3]].inner = i_hwdata[19:0];
                            `RCM_PF_OUTER: d.prof[wdec[5:3]].outer = i_hwdata[19:0];
                            `RCM_PF_TIMERS: begin
                                d.prof[wdec[5:3]].val_ms = i_hwdata[15:0];
                                d.prof[wdec[5:3]].redet_ms = i_hwdata[`RCM_TMR_REDET_LSB+:16];
                            end
                            default: d.diff = q.diff;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
            q.sysper <= `RCM_SYSPER_RST;
            q.stab_ms <= `RCM_STAB_MS_RST;
            q.mon_fault <= 4'hF;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_hrdata = q.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    unstable_fault_a: assert property (!q.stable |-> (faulted | q.byp) == 4'hF)
        else $error("reference not faulted before clock stable");
    override_fault_a: assert property ((q.ovr & ~faulted) == 4'h0)
        else $error("override did not force fault");
    bypass_follow_a: assert property ((q.byp & (faulted ^ q.ovr)) == 4'h0)
        else $error("bypassed fault differs from override");
    pair_single_a: assert property (q.diff[0] && !q.byp[1] |-> faulted[1])
        else $error("unused receiver of differential pair not faulted");
    ms_tick_a: assert property (i_ce && q.tick |=> !q.tick)
        else $error("millisecond tick longer than one cycle");

    sequence s_read_taken;
        i_ce && accept && !i_hwrite;
    endsequence
    sequence s_sel_written;
        i_ce && q.dp_wr && q.dp_addr == `RCM_OFS_SEL;
    endsequence

    read_data_a: assert property (s_read_taken |=> o_hrdata == $past(rd_word))
        else $error("read data not taken from the addressed register");
    rdata_hold_a: assert property (i_ce && !(accept && !i_hwrite) |=> $stable(o_hrdata))
        else $error("read data changed without a read");
    sel_write_a: assert property (s_sel_written |=> q.sel == $past(i_hwdata[15:0]))
        else $error("selection write lost");
    bus_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready and okay");
    stable_hold_a: assert property (i_ce && q.stable && !(q.dp_wr && q.dp_addr == `RCM_OFS_STAB) |=> q.stable)
        else $error("stable dropped without a write");
    stab_write_a: assert property (i_ce && q.dp_wr && q.dp_addr == `RCM_OFS_STAB |=> !q.stable)
        else $error("stability timer not restarted by write");
    sync_chain_a: assert property (i_ce |=> q.s2p == $past(q.s1p) && q.s2n == $past(q.s1n))
        else $error("reference synchroniser skipped a stage");
endmodule : rcm_top

// ---- rcm_top_tb_top.sv ----
// self-checking bench for the four-input reference clock monitor
// assumes the design package, defines header and modules are compiled first
`timescale 1ns/100ps
`include "rcm_defines.svh"
module rcm_top_tb_top;
    localparam logic [11:0] ST = `RCM_OFS_STATUS;
    localparam logic [11:0] OV = `RCM_OFS_OVR;
    localparam logic [11:0] AS = `RCM_OFS_ASSIGN;
    localparam logic [11:0] P0 = 12'h100;
    logic clk, reset, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans, run, ref_p;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, w;
    logic [15:0] half;
    logic [3:0] valid;
    logic [39:0] nom;
    int n_fail, n_compared, seed;

    rcm_top #(.CNT_W(10)) rcm_top_i (.i_clk(clk), .i_reset(reset), .i_ce(1'b1), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout),
        .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_ref_p(ref_p), .i_ref_n({1'b0, ref_p[0]}), .o_valid(valid));
    // one source per pin pair; pair 0 negative pin copies its source, pair 1 negative rests on its pull-down
    rcm_ref_src rcm_ref_src_i[1:0] (.i_clk(clk), .i_run(run), .i_half(half), .o_level(ref_p));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // measured period in fs: two half periods of system clocks, each worth the programmed period
    function automatic logic [39:0] exp_period(input logic [7:0] h);
        return {31'h0, h, 1'b0} * 40'h00FFFFFFFF;
    endfunction : exp_period

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected value at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // status bits change on millisecond ticks, so keep reading under a bounded count
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        int k;
        k = 0;
        ahb(1'b0, a, 32'h0);
        while ((rd & m) !== e && k < 1500) begin
            ahb(1'b0, a, 32'h0);
            k++;
        end
        chk(rd & m, e);
    endtask : poll

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end

    initial begin
        seed = 32'hFB7E602F;
        n_fail = 0;
        n_compared = 0;
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        run = 2'h3;
        half = 16'h0808;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        chk({30'h0, hresp, hreadyout}, 32'h1);
        chk({28'h0, valid}, 32'h0);
        ahb(1'b0, `RCM_OFS_SYSPER, 32'h0);
        chk(rd, 32'h017D7840);
        // a non-word transfer is ignored
        hsize <= 3'h1;
        ahb(1'b1, `RCM_OFS_STAB, 32'h5);
        hsize <= 3'h2;
        ahb(1'b0, `RCM_OFS_STAB, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, ST, 32'h0);
        chk(rd, 32'h000000F0);
        // random fields go to an unused profile whose zero period can never match a reference
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            ahb(1'b1, 12'h1EC, w);
            ahb(1'b1, 12'h1F0, w);
            ahb(1'b0, 12'h1EC, 32'h0);
            chk(rd, w & 32'h000FFFFF);
            ahb(1'b0, 12'h1F0, 32'h0);
            chk(rd, w);
        end
        ahb(1'b1, 12'h01C, w);
        ahb(1'b0, 12'h01C, 32'h0);
        chk(rd, 32'h0);
        nom = exp_period(8'h08);
        ahb(1'b1, `RCM_OFS_STAB, 32'h3);
        ahb(1'b1, P0, nom[31:0]);
        ahb(1'b1, P0 + 12'h4, {24'h0, nom[39:32]});
        ahb(1'b1, P0 + 12'h8, 32'h00004E20);
        ahb(1'b1, P0 + 12'hC, 32'h000003E8);
        ahb(1'b1, P0 + 12'h10, 32'h00030002);
        ahb(1'b1, 12'h130, 32'h00030000);
        ahb(1'b1, `RCM_OFS_SEL, 32'h00008098);
        ahb(1'b1, `RCM_OFS_CFG, 32'h2);
        ahb(1'b1, `RCM_OFS_SYSPER, 32'hFFFFFFFF);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h1F0, 32'h0F0);
        poll(ST, 32'h110, 32'h100);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h1, 32'h0);
        poll(ST, 32'h11, 32'h01);
        chk({31'h0, valid[0]}, 32'h1);
        poll(AS, 32'hF00, 32'h800);
        poll(ST, 32'h44, 32'h04);
        ahb(1'b1, OV, 32'h00000100);
        repeat (2) @(posedge clk);
        chk({31'h0, valid[0]}, 32'h0);
        ahb(1'b1, OV, 32'h0);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h11, 32'h0);
        poll(ST, 32'h11, 32'h01);
        ahb(1'b1, OV, 32'h00020000);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h22, 32'h0);
        repeat (1500) @(posedge clk);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h2, 32'h0);
        ahb(1'b1, OV, 32'h00020002);
        repeat (3) @(posedge clk);
        chk({31'h0, valid[1]}, 32'h1);
        ahb(1'b0, OV, 32'h0);
        chk(rd, 32'h00020000);
        ahb(1'b1, OV, 32'h00020200);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h22, 32'h20);
        ahb(1'b1, OV, 32'h0);
        // nominal 500 ppm off: inside the outer tolerance, outside the inner one
        w = 32'(nom - nom / 40'h7D0);
        ahb(1'b1, P0, w);
        repeat (300) @(posedge clk);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h11, 32'h01);
        // 2000 ppm off fails the outer tolerance; short waits keep ref 2 clear of its redetect timeout
        ahb(1'b1, P0, 32'(nom - nom / 40'h1F4));
        repeat (100) @(posedge clk);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h11, 32'h10);
        ahb(1'b1, P0, w);
        repeat (100) @(posedge clk);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h11, 32'h10);
        ahb(1'b1, P0, nom[31:0]);
        poll(ST, 32'h11, 32'h01);
        run <= 2'h1;
        poll(ST, 32'h44, 32'h40);
        ahb(1'b0, AS, 32'h0);
        chk(rd & 32'hF00, 32'h800);
        poll(AS, 32'hF00, 32'h000);
        ahb(1'b1, `RCM_OFS_SEL, 32'h00008088);
        poll(ST, 32'h22, 32'h02);
        ahb(1'b0, ST, 32'h0);
        chk(rd & 32'h88, 32'h80);
        final_report();
    end
endmodule : rcm_top_tb_top

// ---- rcm_validator.sv ----
// validation latch, validation timer and redetect timer of one reference
// assumes a one-cycle millisecond tick from the same clock
`timescale 1ns/100ps
module rcm_validator import rcm_pkg::*; (
    // clock and control
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // fault and timing
    input wire logic i_faulted,
    input wire logic i_ms_tick,
    input wire logic [15:0] i_val_ms,
    input wire logic [15:0] i_redet_ms,
    input wire logic i_redet_en,
    input wire logic i_force,
    // results
    output logic o_valid,
    output logic o_redetect
);
    rcm_val_t q;
    rcm_val_t d;

    always_comb begin
        d = q;
        d.redet = 1'b0;
        d.fprev = i_faulted;
        if (i_faulted) begin
            d.vcnt = '0;
            d.valid = 1'b0;
        end else if (i_force || (i_val_ms != 16'h0000 && q.vcnt == i_val_ms)) begin
            d.valid = 1'b1;
        end else if (i_ms_tick && i_val_ms != 16'h0000) begin
            d.vcnt = q.vcnt + 16'h0001;
        end
        if (!i_faulted || !i_redet_en || i_redet_ms == 16'h0000) begin
            d.rcnt = '0;
        end else if (!q.fprev) begin
            d.rcnt = '0;
        end else if (i_ms_tick) begin
            if (q.rcnt + 16'h0001 == i_redet_ms) begin
                d.redet = 1'b1;
                d.rcnt = '0;
            end else begin
                d.rcnt = q.rcnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_valid = q.valid;
    assign o_redetect = q.redet;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_expiry;
        i_ce && !i_faulted && i_val_ms != 16'h0000 && q.vcnt == i_val_ms;
    endsequence
    sequence s_new_fault;
        i_ce && i_faulted && !q.fprev;
    endsequence

    fault_invalid_a: assert property (i_ce && i_faulted |=> !o_valid)
        else $error("valid not cleared by fault");
    vtimer_halt_a: assert property (i_ce && i_faulted |=> q.vcnt == 16'h0000)
        else $error("validation timer not reset while faulted");
    expiry_valid_a: assert property (s_expiry |=> o_valid)
        else $error("expiry did not validate");
    force_valid_a: assert property (i_ce && i_force && !i_faulted |=> o_valid)
        else $error("forced timeout did not validate");
    zero_disables_a: assert property (i_ce && i_val_ms == 16'h0000 && !i_force && !o_valid |=> !o_valid)
        else $error("valid set with validation timer disabled");
    redet_restart_a: assert property (s_new_fault |=> q.rcnt == 16'h0000 && !o_redetect)
        else $error("redetect timer not restarted");
    redet_zero_a: assert property (i_ce && i_redet_ms == 16'h0000 |=> !o_redetect)
        else $error("redetect fired while disabled");
endmodule : rcm_validator
